//--- tb.sv
// testbench for the window_upper_bits window block
`timescale 1ns/1ns
`default_nettype none
module tb;
  logic        clk = 1'b0;
  logic        rst = 1'b1;
  logic [7:0]  reg_addr = 8'h00;
  logic        reg_wr = 1'b0;
  logic        reg_rd = 1'b0;
  logic [7:0]  reg_wdata = 8'h00;
  logic        lsn = 1'b1;
  logic        fsn = 1'b1;
  logic        pen = 1'b0;
  logic        std_pal = 1'b0;
  logic [7:0]  rdata;
  logic [15:0] hr;
  logic [12:0] vr;
  logic [2:0]  vc;
  logic [10:0] bt, ba, px_last, lines;
  logic        act;
  logic [7:0]  vals [9];
  logic [7:0]  loff, lcnt, foff, fcnt;
  logic [12:0] code;
  int          num_errors = 0;
  int          checks = 0;
  logic [7:0]  adrs [9] = '{8'h13, 8'h14, 8'h03, 8'h04, 8'h05, 8'h06,
                           8'h07, 8'h08, 8'h09};
  logic [12:0] codes [3] = '{13'h1e00, 13'h1a00, 13'h1200};
  localparam logic [7:0] interlace_mask = 8'h20; // position arbitrary
  always #5 clk = ~clk;
  vscw_window_upper_bits_window uut (.clk(clk), .rst(rst), .reg_addr(reg_addr),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_wdata(reg_wdata),
    .reg_rdata_ff(rdata), .line_sync_pulse_n(lsn), .field_sync_pulse_n(fsn),
    .scaled_pixel_en(pen), .std_pal(std_pal), .horizontal_ratio(hr),
    .vertical_ratio(vr), .vertical_ctrl(vc), .base_line_total_ff(bt),
    .base_line_active_ff(ba), .active_ff(act));
  vscw_host u_host (.clk(clk), .rst(rst), .line_sync_pulse_n(lsn),
    .field_sync_pulse_n(fsn), .scaled_pixel_en(pen), .active_ff(act),
    .px_last_ff(px_last), .lines_ff(lines));
  // =====
  // tasks
  task automatic chk(input logic [15:0] s, input logic [15:0] e);
    checks++;
    if (s !== e) begin
      num_errors++;
      $display("BAD %0t saw %h expected %h", $time, s, e);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    @(posedge clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1;
    chk(rdata, e);
  endtask
  task automatic line();
    @(posedge clk) lsn <= 1'b0;
    @(posedge clk) lsn <= 1'b1;
    repeat (40) begin
      @(posedge clk) pen <= 1'b1;
      @(posedge clk) pen <= 1'b0;
    end
  endtask
  task automatic field(input int n);
    @(posedge clk) fsn <= 1'b0;
    @(posedge clk) fsn <= 1'b1;
    wr(8'h07, 8'hff);
    repeat (n + 1) line();
    #1;
  endtask
  function automatic logic [15:0] kept(input int n, input int c);
    int r;
    int acc;
    int k;
    r = ((8192 - c) & 8191) + 512;
    acc = r - 512;
    k = 0;
    repeat (n) begin
      acc += 512;
      if (acc >= r) begin
        k++;
        acc -= r;
      end
    end
    return 16'(k);
  endfunction
  function automatic logic [7:0] hoff(input int n, input logic pal);
    int d;
    d = pal ? (186 * n) / 922 : (135 * n) / 754;
    return 8'(d & 10'h3fe);
  endfunction
  function automatic logic [12:0] one_field(input int c);
    int r;
    r = (((8192 - c) & 8191) + 512) / 2;
    return 13'((8192 - (r - 512)) & 8191);
  endfunction
  task automatic close_out();
    if (num_errors == 0 && checks > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  // =====
  // main sequence
  initial begin
    #400_000;
    num_errors++;
    close_out();
  end
  initial begin
    void'($urandom(46));
    repeat (16) @(posedge clk);
    rst <= 1'b0;
    foreach (adrs[i]) rd(adrs[i], 8'h00);
    foreach (adrs[i]) begin
      vals[i] = 8'($urandom);
      wr(adrs[i], vals[i]);
      rd(adrs[i], vals[i]);
    end
    rd(8'hff, 8'h00);
    chk(hr, {vals[7], vals[8]});
    chk(vc, {5'h00, vals[0][7:5]});
    for (int p = 0; p < 2; p++) begin
      @(posedge clk) std_pal <= p[0];
      repeat (2) @(posedge clk);
      #1;
      chk(bt, p ? 16'h046f : 16'h038e);
      chk(ba, p ? 16'h039a : 16'h02f2);
    end
    for (int k = 0; k < 6; k++) begin
      code = (k < 3) ? codes[k] : one_field(codes[k - 3]);
      if (k >= 3) vals[0] = vals[0] & ~interlace_mask;
      lcnt = 8'(1 + $urandom % 20);
      loff = (k % 2 == 1) ? hoff(lcnt, std_pal)
                          : 8'(2 * ($urandom % 10));
      foff = 8'($urandom % 4);
      fcnt = 8'(4 + $urandom % 9);
      wr(8'h13, (vals[0] & 8'he0) | {3'h0, code[12:8]});
      wr(8'h14, code[7:0]);
      wr(8'h03, 8'h00);
      wr(8'h04, foff);
      wr(8'h05, fcnt);
      wr(8'h06, loff);
      wr(8'h07, lcnt);
      field(foff + fcnt + 1);
      chk(vr, code);
      chk(px_last, lcnt);
      chk(lines, kept(fcnt, code));
      chk(vc, {5'h00, vals[0][7:5]});
    end
    close_out();
  end
endmodule // tb
`default_nettype wire

//--- vscw_chk.sv
// assertion checker for the window_upper_bits window block
`timescale 1ns/1ns
`default_nettype none
module vscw_chk (
  input wire logic        clk,
  input wire logic        rst,
  input wire logic [7:0]  reg_addr,
  input wire logic        reg_wr,
  input wire logic [7:0]  reg_wdata,
  input wire logic        line_sync_pulse_n,
  input wire logic        field_sync_pulse_n,
  input wire logic        scaled_pixel_en,
  input wire logic        std_pal,
  input wire logic [15:0] horizontal_ratio,
  input wire logic [12:0] vertical_ratio,
  input wire logic [2:0]  vertical_ctrl,
  input wire logic [10:0] base_line_total_ff,
  input wire logic [10:0] base_line_active_ff,
  input wire logic        active_ff
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  sequence s_line; $fell(line_sync_pulse_n); endsequence
  sequence s_field; $rose(field_sync_pulse_n); endsequence
  sequence s_wr(a); reg_wr && reg_addr == a; endsequence
  // =====
  // checks
  AST_BASE_FIG: assert property (!$past(rst) |->
    base_line_total_ff == ($past(std_pal) ? 11'h046f : 11'h038e) &&
    base_line_active_ff == ($past(std_pal) ? 11'h039a : 11'h02f2))
    else $error("base figures wrong");
  AST_HR_HIGH: assert property (s_wr(8'h08) |=>
    horizontal_ratio[15:8] == $past(reg_wdata)) else $error("ratio high");
  AST_HR_LOW: assert property (s_wr(8'h09) |=>
    horizontal_ratio[7:0] == $past(reg_wdata)) else $error("ratio low");
  AST_CTRL_KEEP: assert property (s_wr(8'h13) |=>
    {vertical_ctrl, 5'h00} == ($past(reg_wdata) & 8'he0))
    else $error("upper bits lost");
  AST_VR_HOLD: assert property (!$rose(field_sync_pulse_n) |=>
    $stable(vertical_ratio)) else $error("scale changed mid field");
  AST_ACT_QUIET: assert property (!scaled_pixel_en &&
    !$fell(line_sync_pulse_n) && !$rose(field_sync_pulse_n) |=>
    $stable(active_ff)) else $error("active moved without cause");
  AST_LINE_CLR: assert property (s_line ##0 !scaled_pixel_en |=>
    !active_ff) else $error("active at line start");
  AST_FIELD_CLR: assert property (s_field |=> !active_ff)
    else $error("active at field start");
endmodule // vscw_chk
bind vscw_window_upper_bits_window vscw_chk u_chk (.clk(clk), .rst(rst),
  .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_wdata(reg_wdata),
  .line_sync_pulse_n(line_sync_pulse_n), .std_pal(std_pal),
  .field_sync_pulse_n(field_sync_pulse_n), .active_ff(active_ff),
  .scaled_pixel_en(scaled_pixel_en), .horizontal_ratio(horizontal_ratio),
  .vertical_ratio(vertical_ratio), .vertical_ctrl(vertical_ctrl),
  .base_line_total_ff(base_line_total_ff),
  .base_line_active_ff(base_line_active_ff));
`default_nettype wire

//--- vscw_defines.vh
// constants for the vertical scale and window_upper_bits window block
`ifndef VSCW_DEFINES_VH
`define VSCW_DEFINES_VH
// ==========================================================
// register offsets
`define VSCW_OFS_VERTICAL_RATIO_HIGH   8'h13
`define VSCW_OFS_VERTICAL_RATIO_LOW    8'h14
`define VSCW_OFS_WINDOW_UPPER  8'h03
`define VSCW_OFS_FIELD_OFF_LO  8'h04
`define VSCW_OFS_FIELD_CNT_LO  8'h05
`define VSCW_OFS_LINE_OFF_LO   8'h06
`define VSCW_OFS_LINE_CNT_LO   8'h07
`define VSCW_OFS_HRATIO_HIGH   8'h08
`define VSCW_OFS_HRATIO_LOW    8'h09
// ==========================================================
// field positions
`define VSCW_VSC_HI_MSB        4
`define VSCW_CTRL_LSB          5
`define VSCW_WIN_FOFF_LSB      6
`define VSCW_WIN_FCNT_LSB      4
`define VSCW_WIN_LOFF_LSB      2
`define VSCW_WIN_LCNT_LSB      0
// ==========================================================
// reset values
`define VSCW_RST_VERTICAL_RATIO_HIGH   8'h00
`define VSCW_RST_VERTICAL_RATIO_LOW    8'h00
`define VSCW_RST_WINDOW_UPPER  8'h00
`define VSCW_RST_FIELD_OFF_LO  8'h00
`define VSCW_RST_FIELD_CNT_LO  8'h00
`define VSCW_RST_LINE_OFF_LO   8'h00
`define VSCW_RST_LINE_CNT_LO   8'h00
`define VSCW_RST_HRATIO_HIGH   8'h00
`define VSCW_RST_HRATIO_LOW    8'h00
// ==========================================================
// vertical ratio arithmetic
`define VSCW_VSC_MASK          13'h1fff
`define VSCW_VSC_WRAP          14'h2000
`define VSCW_VSC_UNIT          14'h0200
// ==========================================================
// base-rate sample counts per uncropped line
`define VSCW_NTSC_PORCH        11'h015
`define VSCW_NTSC_DELAY        11'h087
`define VSCW_NTSC_ACTIVE       11'h2f2
`define VSCW_NTSC_TOTAL        11'h38e
`define VSCW_PAL_PORCH         11'h01b
`define VSCW_PAL_DELAY         11'h0ba
`define VSCW_PAL_ACTIVE        11'h39a
`define VSCW_PAL_TOTAL         11'h46f
`endif

//--- vscw_host.sv
// capture host model counting gated pixels and kept lines
`timescale 1ns/1ns
`default_nettype none
module vscw_host (
  input  wire logic        clk,
  input  wire logic        rst,
  input  wire logic        line_sync_pulse_n,
  input  wire logic        field_sync_pulse_n,
  input  wire logic        scaled_pixel_en,
  input  wire logic        active_ff,
  output var  logic [10:0] px_last_ff,
  output var  logic [10:0] lines_ff
);
  logic [10:0] px_ff;
  logic        ls_ff;
  logic        fs_ff;
  // =====
  // gated pixel capture
  always @(posedge clk) begin
    ls_ff <= line_sync_pulse_n;
    fs_ff <= field_sync_pulse_n;
    if (scaled_pixel_en && active_ff) px_ff <= px_ff + 11'h001;
    if (ls_ff && !line_sync_pulse_n) begin
      px_ff <= 11'h000;
      if (px_ff != 11'h000) begin
        px_last_ff <= px_ff;
        lines_ff <= lines_ff + 11'h001;
      end
    end
    if (rst || (!fs_ff && field_sync_pulse_n)) lines_ff <= 11'h000;
    if (rst) px_ff <= 11'h000;
  end
endmodule // vscw_host
`default_nettype wire

//--- vscw_window_upper_bits_window.v
// vertical scale register and window_upper_bits window active flag generator
`timescale 1ns/1ns
`default_nettype none
// Behaviour
// - scale code is 13-bit negative value, (1/ratio-1)*512 subtracted from 0x10000
// - only low 13 bits used: high byte bits 4..0 above low byte
// - active window starts from field sync vertically, line sync horizontally
// - four window values are 10 bits, upper bits in shared register
// - line offset counted in scaled pixels from line sync falling edge
// - exactly line pixel count scaled pixels active per line
// - uncropped base-rate counts: NTSC 21/135/754/910, PAL 27/186/922/1135
// - skip field line offset lines after field sync rising edge
// - field line count lines enter scaling, count times ratio output
// - vertical counts in input lines, horizontal in scaled pixels
// - horizontal ratio is two 8-bit registers joined into 16 bits
`include "vscw_defines.vh"

module vscw_window_upper_bits_window (
  input  wire        clk,
  input  wire        rst,
  input  wire [7:0]  reg_addr,
  input  wire        reg_wr,
  input  wire        reg_rd,
  input  wire [7:0]  reg_wdata,
  output reg  [7:0]  reg_rdata_ff,
  input  wire        line_sync_pulse_n,
  input  wire        field_sync_pulse_n,
  input  wire        scaled_pixel_en,
  input  wire        std_pal,
  output wire [15:0] horizontal_ratio,
  output wire [12:0] vertical_ratio,
  output wire [2:0]  vertical_ctrl,
  output reg  [10:0] base_line_total_ff,
  output reg  [10:0] base_line_active_ff,
  output reg         active_ff
);

  // ========================================================
  // decode helpers
  function [13:0] ratio_q9;
    input [12:0] code;
    reg   [13:0] neg;
    begin
      neg      = `VSCW_VSC_WRAP - {1'b0, code};
      ratio_q9 = {1'b0, neg[12:0]} + `VSCW_VSC_UNIT;
    end
  endfunction

  function [9:0] join10;
    input [7:0] upper;
    input integer lsb;
    input [7:0] low;
    begin
      join10 = {upper[lsb+1], upper[lsb], low};
    end
  endfunction

  // one-hot register select, shared by write and read
  function [8:0] reg_sel;
    input [7:0] addr;
    begin
      case (addr)
        `VSCW_OFS_VERTICAL_RATIO_HIGH:  reg_sel = 9'h001;
        `VSCW_OFS_VERTICAL_RATIO_LOW:   reg_sel = 9'h002;
        `VSCW_OFS_WINDOW_UPPER: reg_sel = 9'h004;
        `VSCW_OFS_FIELD_OFF_LO: reg_sel = 9'h008;
        `VSCW_OFS_FIELD_CNT_LO: reg_sel = 9'h010;
        `VSCW_OFS_LINE_OFF_LO:  reg_sel = 9'h020;
        `VSCW_OFS_LINE_CNT_LO:  reg_sel = 9'h040;
        `VSCW_OFS_HRATIO_HIGH:  reg_sel = 9'h080;
        `VSCW_OFS_HRATIO_LOW:   reg_sel = 9'h100;
        default:                reg_sel = 9'h000;
      endcase
    end
  endfunction

  // upper-bit pair position of each window value
  function integer win_lsb;
    input integer idx;
    begin
      case (idx)
        0:       win_lsb = `VSCW_WIN_LCNT_LSB;
        1:       win_lsb = `VSCW_WIN_LOFF_LSB;
        2:       win_lsb = `VSCW_WIN_FCNT_LSB;
        default: win_lsb = `VSCW_WIN_FOFF_LSB;
      endcase
    end
  endfunction

  // position inside a start/length span
  function in_span;
    input [10:0] pos;
    input [9:0]  start;
    input [9:0]  len;
    reg   [10:0] stop;
    begin
      stop    = {1'b0, start} + {1'b0, len};
      in_span = (pos >= {1'b0, start}) && (pos < stop);
    end
  endfunction

  // ========================================================
  // register file
  reg [7:0] vsc_hi_ff;
  reg [7:0] vsc_lo_ff;
  reg [7:0] win_up_ff;
  reg [7:0] foff_lo_ff;
  reg [7:0] fcnt_lo_ff;
  reg [7:0] loff_lo_ff;
  reg [7:0] lcnt_lo_ff;
  reg [7:0] hr_hi_ff;
  reg [7:0] hr_lo_ff;
  reg [7:0] nxt_rdata;
  wire [8:0] sel;

  assign sel = reg_sel(reg_addr);

  always @(posedge clk) begin
    if (rst) begin
      vsc_hi_ff  <= `VSCW_RST_VERTICAL_RATIO_HIGH;
      vsc_lo_ff  <= `VSCW_RST_VERTICAL_RATIO_LOW;
      win_up_ff  <= `VSCW_RST_WINDOW_UPPER;
      foff_lo_ff <= `VSCW_RST_FIELD_OFF_LO;
      fcnt_lo_ff <= `VSCW_RST_FIELD_CNT_LO;
      loff_lo_ff <= `VSCW_RST_LINE_OFF_LO;
      lcnt_lo_ff <= `VSCW_RST_LINE_CNT_LO;
      hr_hi_ff   <= `VSCW_RST_HRATIO_HIGH;
      hr_lo_ff   <= `VSCW_RST_HRATIO_LOW;
    end else if (reg_wr) begin
      if (sel[0]) vsc_hi_ff  <= reg_wdata;
      if (sel[1]) vsc_lo_ff  <= reg_wdata;
      if (sel[2]) win_up_ff  <= reg_wdata;
      if (sel[3]) foff_lo_ff <= reg_wdata;
      if (sel[4]) fcnt_lo_ff <= reg_wdata;
      if (sel[5]) loff_lo_ff <= reg_wdata;
      if (sel[6]) lcnt_lo_ff <= reg_wdata;
      if (sel[7]) hr_hi_ff   <= reg_wdata;
      if (sel[8]) hr_lo_ff   <= reg_wdata;
    end
  end

  always @* begin
    nxt_rdata = 8'h00;
    if (sel[0]) nxt_rdata = vsc_hi_ff;
    if (sel[1]) nxt_rdata = vsc_lo_ff;
    if (sel[2]) nxt_rdata = win_up_ff;
    if (sel[3]) nxt_rdata = foff_lo_ff;
    if (sel[4]) nxt_rdata = fcnt_lo_ff;
    if (sel[5]) nxt_rdata = loff_lo_ff;
    if (sel[6]) nxt_rdata = lcnt_lo_ff;
    if (sel[7]) nxt_rdata = hr_hi_ff;
    if (sel[8]) nxt_rdata = hr_lo_ff;
  end

  always @(posedge clk) begin
    if (rst) begin
      reg_rdata_ff <= 8'h00;
    end else if (reg_rd) begin
      reg_rdata_ff <= nxt_rdata;
    end
  end

  // ========================================================
  // outputs toward the scaler
  assign horizontal_ratio = {hr_hi_ff, hr_lo_ff};
  assign vertical_ctrl    = vsc_hi_ff[7:`VSCW_CTRL_LSB];

  // ========================================================
  // base-rate line figures
  always @(posedge clk) begin
    if (rst) begin
      base_line_total_ff  <= `VSCW_NTSC_TOTAL;
      base_line_active_ff <= `VSCW_NTSC_ACTIVE;
    end else if (std_pal) begin
      base_line_total_ff  <= `VSCW_PAL_TOTAL;
      base_line_active_ff <= `VSCW_PAL_ACTIVE;
    end else begin
      base_line_total_ff  <= `VSCW_NTSC_TOTAL;
      base_line_active_ff <= `VSCW_NTSC_ACTIVE;
    end
  end

  // ========================================================
  // sync edge detection
  reg  lsync_d_ff;
  reg  fsync_d_ff;
  wire line_start;
  wire field_start;

  always @(posedge clk) begin
    if (rst) begin
      lsync_d_ff <= 1'b1;
      fsync_d_ff <= 1'b1;
    end else begin
      lsync_d_ff <= line_sync_pulse_n;
      fsync_d_ff <= field_sync_pulse_n;
    end
  end

  assign line_start  = lsync_d_ff & ~line_sync_pulse_n;
  assign field_start = ~fsync_d_ff & field_sync_pulse_n;

  // ========================================================
  // field shadow copies
  reg  [12:0] vsc_act_ff;
  reg  [9:0]  foff_act_ff;
  reg  [9:0]  fcnt_act_ff;
  reg  [9:0]  loff_act_ff;
  reg  [9:0]  lcnt_act_ff;
  wire [12:0] vsc_prog;
  wire [31:0] win_low;
  wire [39:0] win_prog;
  genvar      gi;

  assign vsc_prog = {vsc_hi_ff[`VSCW_VSC_HI_MSB:0], vsc_lo_ff};
  assign vertical_ratio = vsc_act_ff;

  assign win_low = {foff_lo_ff, fcnt_lo_ff, loff_lo_ff, lcnt_lo_ff};

  generate
    for (gi = 0; gi < 4; gi = gi + 1) begin : g_win
      assign win_prog[gi*10 +: 10] =
        join10(win_up_ff, win_lsb(gi), win_low[gi*8 +: 8]);
    end
  endgenerate

  always @(posedge clk) begin
    if (rst) begin
      vsc_act_ff  <= 13'h0000;
      foff_act_ff <= 10'h000;
      fcnt_act_ff <= 10'h000;
      loff_act_ff <= 10'h000;
      lcnt_act_ff <= 10'h000;
    end else if (field_start) begin
      vsc_act_ff  <= vsc_prog & `VSCW_VSC_MASK;
      foff_act_ff <= win_prog[39:30];
      fcnt_act_ff <= win_prog[29:20];
      loff_act_ff <= win_prog[19:10];
      lcnt_act_ff <= win_prog[9:0];
    end
  end

  // ========================================================
  // vertical line counting and line dropping
  reg  [10:0] vcnt_ff;
  reg  [13:0] acc_ff;
  reg         line_keep_ff;
  wire        v_in;
  wire [13:0] r_act;
  wire [13:0] r_new;
  wire [13:0] acc_sum;
  wire        hit;

  assign r_act   = ratio_q9(vsc_act_ff);
  assign r_new   = ratio_q9(vsc_prog & `VSCW_VSC_MASK);
  assign v_in    = in_span(vcnt_ff, foff_act_ff, fcnt_act_ff);
  assign acc_sum = acc_ff + `VSCW_VSC_UNIT;
  assign hit     = acc_sum >= r_act;

  always @(posedge clk) begin
    if (rst) begin
      vcnt_ff      <= 11'h7ff;
      acc_ff       <= 14'h0000;
      line_keep_ff <= 1'b0;
    end else if (field_start) begin
      vcnt_ff      <= 11'h000;
      acc_ff       <= r_new - `VSCW_VSC_UNIT;
      line_keep_ff <= 1'b0;
    end else if (line_start) begin
      if (vcnt_ff != 11'h7ff) begin
        vcnt_ff <= vcnt_ff + 11'h001;
      end
      line_keep_ff <= v_in && hit;
      if (v_in) begin
        acc_ff <= hit ? (acc_sum - r_act) : acc_sum;
      end
    end
  end

  // ========================================================
  // horizontal pixel counting and active flag
  reg  [10:0] hcnt_ff;
  wire        h_in;

  assign h_in  = in_span(hcnt_ff, loff_act_ff, lcnt_act_ff);

  always @(posedge clk) begin
    if (rst) begin
      hcnt_ff <= 11'h000;
    end else if (line_start) begin
      hcnt_ff <= 11'h000;
    end else if (scaled_pixel_en && hcnt_ff != 11'h7ff) begin
      hcnt_ff <= hcnt_ff + 11'h001;
    end
  end

  always @(posedge clk) begin
    if (rst) begin
      active_ff <= 1'b0;
    end else if (line_start || field_start) begin
      active_ff <= 1'b0;
    end else if (scaled_pixel_en) begin
      active_ff <= h_in && line_keep_ff;
    end
  end

endmodule // vscw_window_upper_bits_window
`default_nettype wire
